// File: core/qdsc_defs.vh
// Purpose: Constants for the quad converter serial command port
// Assumes: Included by core/qdsc_port.v
// Notes:   Frame layout and command codes
`ifndef QDSC_DEFS_VH
`define QDSC_DEFS_VH

`define QDSC_FRAME_BITS   16
`define QDSC_DATA_BITS    12
`define QDSC_CODE_MSB     15
`define QDSC_CODE_LSB     12
`define QDSC_ADDR_MSB     15
`define QDSC_ADDR_LSB     14
`define QDSC_DATA_MSB     11
`define QDSC_DATA_LSB     0
`define QDSC_CNT_W        5
`define QDSC_SAMPLE_ZERO  12'h000

`define QDSC_CMD_NOP      4'h0
`define QDSC_CMD_UPO_LO   4'h2
`define QDSC_CMD_UPDATE   4'h4
`define QDSC_CMD_UPO_HI   4'h6
`define QDSC_CMD_LOAD_ALL 4'h8
`define QDSC_CMD_EDGE_F   4'ha
`define QDSC_CMD_SHDN     4'hc
`define QDSC_CMD_EDGE_R   4'he

`define QDSC_CTRL_LOAD    2'h1
`define QDSC_CTRL_LOADUPD 2'h3

`endif

// File: core/qdsc_port.v
// Purpose: Serial command port of a four-channel 12-bit converter
// Assumes: Serial pins are asynchronous to clock and sampled by it
// Notes:   Link clock slower than clock by a wide margin
`timescale 1ns/100ps
`include "qdsc_defs.vh"

module qdsc_port #(
  parameter DATA_W = 12
) (
  input  wire              clock,
  input  wire              rstn,
  input  wire              clk_en,
  input  wire              sclk,
  input  wire              cs_n,
  input  wire              sdin,
  input  wire              clear_all_n,
  input  wire              shutdown_lockout_n,
  output reg               sdout,
  output reg               user_logic_out,
  output reg               shutdown,
  output reg               echo_rising,
  output reg  [DATA_W-1:0] input_a,
  output reg  [DATA_W-1:0] input_b,
  output reg  [DATA_W-1:0] input_c,
  output reg  [DATA_W-1:0] input_d,
  output reg  [DATA_W-1:0] conv_a,
  output reg  [DATA_W-1:0] conv_b,
  output reg  [DATA_W-1:0] conv_c,
  output reg  [DATA_W-1:0] conv_d
);

  // Three-stage samplers for asynchronous pins
  reg [2:0] sclk_s_q;
  reg [2:0] cs_s_q;
  reg [2:0] din_s_q;
  reg [2:0] clr_s_q;
  reg [2:0] pdl_s_q;
  reg       sclk_q;
  reg       cs_q;
  reg       din_q;
  reg       clr_q;
  reg       pdl_q;

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sclk_s_q <= 3'h0;
      cs_s_q   <= 3'h7;
      din_s_q  <= 3'h0;
      clr_s_q  <= 3'h7;
      pdl_s_q  <= 3'h0;
      sclk_q   <= 1'b0;
      cs_q     <= 1'b1;
      din_q    <= 1'b0;
      clr_q    <= 1'b1;
      pdl_q    <= 1'b0;
    end else if (clk_en) begin
      sclk_s_q <= {sclk_s_q[1:0], sclk};
      cs_s_q   <= {cs_s_q[1:0], cs_n};
      din_s_q  <= {din_s_q[1:0], sdin};
      clr_s_q  <= {clr_s_q[1:0], clear_all_n};
      pdl_s_q  <= {pdl_s_q[1:0], shutdown_lockout_n};
      if (sclk_s_q[2] == sclk_s_q[1])
        sclk_q <= sclk_s_q[2];
      if (cs_s_q[2] == cs_s_q[1])
        cs_q <= cs_s_q[2];
      if (din_s_q[2] == din_s_q[1])
        din_q <= din_s_q[2];
      if (clr_s_q[2] == clr_s_q[1])
        clr_q <= clr_s_q[2];
      if (pdl_s_q[2] == pdl_s_q[1])
        pdl_q <= pdl_s_q[2];
    end
  end

  // Filtered values with one more stage for edge finding
  wire sclk_new = (sclk_s_q[2] == sclk_s_q[1]) ? sclk_s_q[2] : sclk_q;
  wire cs_new   = (cs_s_q[2] == cs_s_q[1]) ? cs_s_q[2] : cs_q;
  wire pdl_new  = (pdl_s_q[2] == pdl_s_q[1]) ? pdl_s_q[2] : pdl_q;
  wire din_new  = (din_s_q[2] == din_s_q[1]) ? din_s_q[2] : din_q;

  wire sclk_rise = clk_en & sclk_new & ~sclk_q;
  wire sclk_fall = clk_en & ~sclk_new & sclk_q;
  wire cs_rise   = clk_en & cs_new & ~cs_q;
  wire pdl_fall  = clk_en & ~pdl_new & pdl_q;

  // Shift register and frame bit counter
  reg  [`QDSC_FRAME_BITS-1:0] shift_q;
  reg  [`QDSC_CNT_W-1:0]      count_q;
  reg                         last_q;

  wire [3:0]        code  = shift_q[`QDSC_CODE_MSB:`QDSC_CODE_LSB];
  wire [1:0]        addr  = shift_q[`QDSC_ADDR_MSB:`QDSC_ADDR_LSB];
  wire [1:0]        ctrl  = code[1:0];
  wire [DATA_W-1:0] field = shift_q[`QDSC_DATA_MSB:`QDSC_DATA_LSB];
  wire              full  = (count_q == `QDSC_FRAME_BITS);
  wire              exec  = cs_rise & full;

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      shift_q <= 16'h0000;
      count_q <= 5'h00;
      last_q  <= 1'b0;
    end else if (!clr_q) begin
      shift_q <= 16'h0000;
      count_q <= 5'h00;
      last_q  <= 1'b0;
    end else if (clk_en) begin
      if (cs_q) begin
        count_q <= 5'h00;
      end else if (sclk_rise) begin
        last_q  <= shift_q[`QDSC_FRAME_BITS-1];
        shift_q <= {shift_q[`QDSC_FRAME_BITS-2:0], din_new};
        if (!full)
          count_q <= count_q + 5'h01;
      end
    end
  end

  // Echo output, launched on the selected link edge
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sdout <= 1'b0;
    end else if (!clr_q) begin
      sdout <= 1'b0;
    end else if (clk_en && !cs_q) begin
      if (echo_rising && sclk_rise)
        sdout <= shift_q[`QDSC_FRAME_BITS-1];
      else if (!echo_rising && sclk_fall)
        sdout <= last_q;
    end
  end

  // Command execution on select release
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      input_a        <= `QDSC_SAMPLE_ZERO;
      input_b        <= `QDSC_SAMPLE_ZERO;
      input_c        <= `QDSC_SAMPLE_ZERO;
      input_d        <= `QDSC_SAMPLE_ZERO;
      conv_a         <= `QDSC_SAMPLE_ZERO;
      conv_b         <= `QDSC_SAMPLE_ZERO;
      conv_c         <= `QDSC_SAMPLE_ZERO;
      conv_d         <= `QDSC_SAMPLE_ZERO;
      user_logic_out <= 1'b0;
      shutdown       <= 1'b0;
      echo_rising    <= 1'b0;
    end else if (!clr_q) begin
      input_a        <= `QDSC_SAMPLE_ZERO;
      input_b        <= `QDSC_SAMPLE_ZERO;
      input_c        <= `QDSC_SAMPLE_ZERO;
      input_d        <= `QDSC_SAMPLE_ZERO;
      conv_a         <= `QDSC_SAMPLE_ZERO;
      conv_b         <= `QDSC_SAMPLE_ZERO;
      conv_c         <= `QDSC_SAMPLE_ZERO;
      conv_d         <= `QDSC_SAMPLE_ZERO;
      user_logic_out <= 1'b0;
      shutdown       <= 1'b0;
      echo_rising    <= 1'b0;
    end else if (clk_en) begin
      if (pdl_fall && shutdown)
        shutdown <= 1'b0;
      if (exec) begin
        if (ctrl == `QDSC_CTRL_LOAD) begin
          case (addr)
            2'h0: input_a <= field;
            2'h1: input_b <= field;
            2'h2: input_c <= field;
            default: input_d <= field;
          endcase
        end else if (ctrl == `QDSC_CTRL_LOADUPD) begin
          conv_a <= (addr == 2'h0) ? field : input_a;
          conv_b <= (addr == 2'h1) ? field : input_b;
          conv_c <= (addr == 2'h2) ? field : input_c;
          conv_d <= (addr == 2'h3) ? field : input_d;
          case (addr)
            2'h0: input_a <= field;
            2'h1: input_b <= field;
            2'h2: input_c <= field;
            default: input_d <= field;
          endcase
        end else begin
          case (code)
            `QDSC_CMD_UPDATE: begin
              conv_a   <= input_a;
              conv_b   <= input_b;
              conv_c   <= input_c;
              conv_d   <= input_d;
              shutdown <= 1'b0;
            end
            `QDSC_CMD_LOAD_ALL: begin
              input_a  <= field;
              input_b  <= field;
              input_c  <= field;
              input_d  <= field;
              conv_a   <= field;
              conv_b   <= field;
              conv_c   <= field;
              conv_d   <= field;
              shutdown <= 1'b0;
            end
            `QDSC_CMD_SHDN: begin
              if (pdl_new)
                shutdown <= 1'b1;
            end
            `QDSC_CMD_UPO_LO: user_logic_out <= 1'b0;
            `QDSC_CMD_UPO_HI: user_logic_out <= 1'b1;
            `QDSC_CMD_EDGE_R, `QDSC_CMD_EDGE_F: begin
              echo_rising <= (code == `QDSC_CMD_EDGE_R);
              conv_a      <= input_a;
              conv_b      <= input_b;
              conv_c      <= input_c;
              conv_d      <= input_d;
            end
            default: ;
          endcase
        end
      end
    end
  end

endmodule

// File: dv/qdsc_port_asserts.sv
// Purpose: Pin assertions
// Assumes: Pins seen 3 to 6 clocks late
// Notes:   Bound below
`timescale 1ns/100ps
module qdsc_chk #(
  parameter DATA_W = 12
) (
  input wire              clock,
  input wire              rstn,
  input wire              sclk,
  input wire              cs_n,
  input wire              clear_all_n,
  input wire              shutdown_lockout_n,
  input wire              sdout,
  input wire              user_logic_out,
  input wire              shutdown,
  input wire              echo_rising,
  input wire [DATA_W-1:0] input_a,
  input wire [DATA_W-1:0] conv_a
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence s_idle; (cs_n && clear_all_n) [*8]; endsequence
  sequence s_busy; (!cs_n && clear_all_n) [*8]; endsequence
  sequence s_clr_ok; clear_all_n && $past(clear_all_n, 6); endsequence
  property p_hold; s_busy |=> $stable({input_a, conv_a, user_logic_out}); endproperty
  a_hold: assert property (p_hold) else $error("moved in frame");
  property p_quiet; s_idle |=> $stable(sdout); endproperty
  a_quiet: assert property (p_quiet) else $error("echo moved");
  property p_flag; $changed({user_logic_out, echo_rising}) |-> $past(cs_n, 3); endproperty
  a_flag: assert property (p_flag) else $error("flag early");
  property p_conv; s_clr_ok ##0 $changed(conv_a) |-> $past(cs_n, 3) && cs_n; endproperty
  a_conv: assert property (p_conv) else $error("conv early");
  property p_lock; !shutdown_lockout_n [*8] |-> !shutdown; endproperty
  a_lock: assert property (p_lock) else $error("shutdown locked");
  property p_shdn; $rose(shutdown) |-> $past(shutdown_lockout_n, 4) && cs_n; endproperty
  a_shdn: assert property (p_shdn) else $error("bad shutdown");
  property p_clr; !clear_all_n [*8] |-> !sdout && !user_logic_out && conv_a == 0; endproperty
  a_clr: assert property (p_clr) else $error("clear");
  property p_edge; s_clr_ok ##0 $changed(sdout) |-> $past(sclk, 3) == echo_rising; endproperty
  a_edge: assert property (p_edge) else $error("echo edge");
endmodule
bind qdsc_port qdsc_chk #(.DATA_W(DATA_W)) i_chk (.clock, .rstn, .sclk, .cs_n, .clear_all_n,
  .shutdown_lockout_n, .sdout, .user_logic_out, .shutdown, .echo_rising, .input_a, .conv_a);

// File: dv/qdsc_host.sv
// Purpose: Host serial port model
// Assumes: Link period 8 clocks
// Notes:   Echo sampled two clocks after the next rise
`timescale 1ns/100ps
module qdsc_host (
  input  wire clock,
  output reg  sclk,
  output reg  cs_n,
  output reg  sdin,
  input  wire sdout
);
  reg [15:0] echo_q;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdin = 1'b0;
    echo_q = 16'h0000;
  end
  task send(input [15:0] w, input integer n);
    integer i;
    reg [15:0] s;
    begin
      s = w;
      @(posedge clock);
      cs_n <= 1'b0;
      sdin <= s[15];
      repeat (4) @(posedge clock);
      for (i = 0; i < n; i = i + 1) begin
        sclk <= 1'b1;
        repeat (2) @(posedge clock);
        if (i > 0)
          echo_q <= {echo_q[14:0], sdout};
        repeat (2) @(posedge clock);
        sclk <= 1'b0;
        s = s << 1;
        sdin <= s[15];
        repeat (4) @(posedge clock);
      end
      repeat (2) @(posedge clock);
      echo_q <= {echo_q[14:0], sdout};
      repeat (2) @(posedge clock);
      cs_n <= 1'b1;
      sdin <= ~sdin;
    end
  endtask
endmodule

// File: dv/qdsc_port_tb_top.sv
// Purpose: Command port bench
// Assumes: Outputs settle 10 clocks after a frame
// Notes:   Fixed commands
`timescale 1ns/100ps
module qdsc_port_tb_top;
  reg clock = 1'b0;
  reg rstn = 1'b0;
  reg clear_all_n = 1'b1;
  reg shutdown_lockout_n = 1'b1;
  reg clk_en = 1'b1;
  wire sclk, cs_n, sdin, sdout, user_logic_out, shutdown, echo_rising;
  wire [11:0] input_a, input_b, input_c, input_d, conv_a, conv_b, conv_c, conv_d;
  integer n_errors = 0, n_compared = 0, cycles = 0;
  always #5 clock = ~clock;
  qdsc_host i_host (.clock, .sclk, .cs_n, .sdin, .sdout);
  qdsc_port i_dut (.clock, .rstn, .clk_en, .sclk, .cs_n, .sdin, .clear_all_n,
    .shutdown_lockout_n, .sdout, .user_logic_out, .shutdown, .echo_rising, .input_a,
    .input_b, .input_c, .input_d, .conv_a, .conv_b, .conv_c, .conv_d);
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("mismatch %0t saw %h want %h", $time, seen, exp);
      end
    end
  endtask
  task cmd(input [15:0] w, input integer n);
    begin
      i_host.send(w, n);
      repeat (10) @(posedge clock);
    end
  endtask
  task results;
    begin
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      n_errors = n_errors + 1;
      results;
    end
  end
  initial begin
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    repeat (6) @(posedge clock);
    chk({echo_rising, conv_a}, 0);
    cmd(16'h1abc, 16);
    chk({input_a, conv_a}, 24'habc000);
    cmd(16'h7123, 16);
    chk({conv_a, conv_b}, 24'habc123);
    cmd(16'h5456, 16);
    chk(conv_b, 12'h123);
    cmd(16'h4fff, 16);
    chk(conv_b, 12'h456);
    cmd(16'h0fff, 16);
    chk({input_a, conv_b}, 24'habc456);
    cmd(16'h6000, 16);
    chk(user_logic_out, 1);
    cmd(16'h2000, 16);
    chk(user_logic_out, 0);
    cmd(16'h9777, 16);
    cmd(16'he000, 16);
    chk({echo_rising, conv_c}, 13'h1777);
    cmd(16'h0000, 16);
    chk(i_host.echo_q, 16'he000);
    cmd(16'ha000, 16);
    chk(echo_rising, 0);
    cmd(16'h0000, 16);
    chk(i_host.echo_q, 16'ha000);
    shutdown_lockout_n <= 1'b0;
    cmd(16'hc000, 16);
    chk(shutdown, 0);
    shutdown_lockout_n <= 1'b1;
    cmd(16'hc000, 16);
    chk(shutdown, 1);
    cmd(16'h4000, 16);
    chk(shutdown, 0);
    cmd(16'hc000, 16);
    cmd(16'h8321, 16);
    chk({shutdown, input_d, conv_c}, 25'h0321321);
    cmd(16'hc000, 16);
    cmd(16'h1111, 16);
    shutdown_lockout_n <= 1'b0;
    repeat (10) @(posedge clock);
    chk({shutdown, input_a, conv_a}, 25'h0111321);
    shutdown_lockout_n <= 1'b1;
    cmd(16'h1777, 8);
    chk(input_a, 12'h111);
    clk_en <= 1'b0;
    cmd(16'h6000, 16);
    chk(user_logic_out, 0);
    clk_en <= 1'b1;
    repeat (4) @(posedge clock);
    cmd(16'h6000, 16);
    clear_all_n <= 1'b0;
    repeat (8) @(posedge clock);
    chk({user_logic_out, sdout, input_a, conv_d}, 0);
    clear_all_n <= 1'b1;
    repeat (8) @(posedge clock);
    results;
  end
endmodule
